/* File: dmairq_defs.svh */
// Offsets, field positions, reset values and timing counts of the DMA interrupt logic
`ifndef DMAIRQ_DEFS_SVH
`define DMAIRQ_DEFS_SVH
`define DMAIRQ_OFF_CTRL 4'h0
`define DMAIRQ_OFF_VECT 4'h4
`define DMAIRQ_OFF_STAT 4'h8
`define DMAIRQ_OFF_CMD 4'hc
`define DMAIRQ_CTRL_IRQ_EN 0
`define DMAIRQ_CTRL_IOR 1
`define DMAIRQ_CTRL_CONT 2
`define DMAIRQ_CTRL_SAV 3
`define DMAIRQ_CMD_ENABLE 0
`define DMAIRQ_CMD_DISABLE 1
`define DMAIRQ_CMD_RETURN 2
`define DMAIRQ_CMD_RESET_IRQ 3
`define DMAIRQ_CMD_DONE 4
`define DMAIRQ_STAT_PEND 0
`define DMAIRQ_STAT_INSVC 1
`define DMAIRQ_STAT_BUS_REQUEST_N 2
`define DMAIRQ_STAT_ENABLED 3
`define DMAIRQ_STAT_RDY 4
`define DMAIRQ_CTRL_RST 4'h0
`define DMAIRQ_VECT_RST 8'h00
`define DMAIRQ_RET_OP0 8'hed
`define DMAIRQ_RET_OP1 8'h4d
`define DMAIRQ_BUS_REQUEST_N_MAX_CYC 2
`endif

/* File: dmairq_pkg.sv */
// Types of the DMA interrupt logic
package dmairq_pkg;
  // Return-opcode decoder states, one-hot
  typedef enum logic [2:0] {
    DMAIRQ_RET_IDLE = 3'b001,
    DMAIRQ_RET_GOT_ED = 3'b010,
    DMAIRQ_RET_HIT = 3'b100
  } dmairq_ret_t;
endpackage

/* File: dmairq_top.sv */
// Interrupt logic of a byte-wide DMA controller with Avalon-MM register slave
//
// Function
// - Drive 8-bit vector on data bus during the host acknowledge cycle.
// - Vector may optionally carry present status bits in its low bits.
// - Pending latch sets on unacknowledged request; holds interrupt request low.
// - In-service latch sets on acknowledge; no further requests while set.
// - While in service, hold chain-enable output low.
// - While in service, never assert bus request.
// - Pending latch clears when in-service latch sets.
// - Lasting cause re-sets pending at once when in-service clears.
// - In-service clears by return opcode or by a control byte.
// - Without interrupt-on-ready, ready active drives bus request low within two cycles.
// - With interrupt-on-ready, ready raises interrupt instead of bus request.
// - Continuous mode with interrupt-on-ready interrupts only on first ready.
// - Watch data bus during opcode fetch and decode return opcode ED4D.
// - Return opcode clears in-service so chain-enable output may rise.
// - Return opcode re-enables bus request only with interrupt-on-ready and enable.
// - Hold priority and place vector only while chain-enable input high.
// - Device needing service drives chain-enable output low.
// - Low chain-enable input propagates to chain-enable output.
// - Once bus won, keep it until the task completes.
// - Accept control bytes reproducing the return opcode's effects.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "dmairq_defs.svh"
module dmairq_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Avalon-MM register slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Host bus pins
  input wire logic i_opcode_fetch_n,
  input wire logic i_io_request_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Interrupt and daisy chain
  output logic o_int_n,
  input wire logic i_chain_enable_in,
  output logic o_chain_enable_out,
  // Bus-request logic
  input wire logic i_ready,
  input wire logic i_block_cause,
  input wire logic i_task_done,
  output logic o_bus_request_n
);
  import dmairq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      // Idle pin levels, so no false ready or fetch edge follows reset
      sync1_q <= 12'he00;
      sync2_q <= 12'he00;
    end else begin
      sync1_q <= {i_opcode_fetch_n, i_io_request_n, i_chain_enable_in, i_ready, i_data};
      sync2_q <= sync1_q;
    end
  end
  logic fetch_n_s;
  logic ioreq_n_s;
  logic iei_s;
  logic ready_s;
  logic [7:0] data_s;
  assign fetch_n_s = sync2_q[11];
  assign ioreq_n_s = sync2_q[10];
  assign iei_s = sync2_q[9];
  assign ready_s = sync2_q[8];
  assign data_s = sync2_q[7:0];

  // Edge detection on synchronised strobes
  logic fetch_n_prev_q;
  logic ready_prev_q;
  logic ack_prev_q;
  logic ack_s;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fetch_n_prev_q <= 1'b1;
      ready_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      fetch_n_prev_q <= fetch_n_s;
      ready_prev_q <= ready_s;
      ack_prev_q <= ack_s;
    end
  end
  assign ack_s = !fetch_n_s && !ioreq_n_s;
  logic ready_rise;
  logic ack_start;
  logic fetch_start;
  assign ready_rise = ready_s && !ready_prev_q;
  assign ack_start = ack_s && !ack_prev_q;
  // Opcode byte is taken once per fetch cycle, on its first low sample
  assign fetch_start = !fetch_n_s && fetch_n_prev_q && ioreq_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [3:0] ctrl_q;
  logic [7:0] vect_q;
  logic enabled_q;
  logic bus_req_q;
  logic pend_q;
  logic insvc_q;
  logic rd_ack_q;
  logic [31:0] rdata_d;
  logic wr_cmd;
  logic [7:0] cmd_byte;
  assign wr_cmd = i_avs_write && (i_avs_address == `DMAIRQ_OFF_CMD);
  assign cmd_byte = i_avs_writedata[7:0];

  // Writes complete with no wait; reads take one wait cycle so data is registered
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `DMAIRQ_CTRL_RST;
      vect_q <= `DMAIRQ_VECT_RST;
    end else if (i_avs_write) begin
      if (i_avs_address == `DMAIRQ_OFF_CTRL) begin
        ctrl_q <= i_avs_writedata[3:0];
      end
      if (i_avs_address == `DMAIRQ_OFF_VECT) begin
        vect_q <= i_avs_writedata[7:0];
      end
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (i_avs_address)
      `DMAIRQ_OFF_CTRL: rdata_d = {28'h000_0000, ctrl_q};
      `DMAIRQ_OFF_VECT: rdata_d = {24'h00_0000, vect_q};
      `DMAIRQ_OFF_STAT: rdata_d = {27'h000_0000, ready_s, enabled_q, bus_req_q, insvc_q, pend_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_ack_q <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack_q <= i_avs_read && !rd_ack_q;
      if (i_avs_read && !rd_ack_q) begin
        o_avs_readdata <= rdata_d;
      end
    end
  end
  assign o_avs_waitrequest = i_avs_read && !rd_ack_q;

  logic ior_en;
  logic cont_mode;
  logic irq_en;
  assign irq_en = ctrl_q[`DMAIRQ_CTRL_IRQ_EN];
  assign ior_en = ctrl_q[`DMAIRQ_CTRL_IOR];
  assign cont_mode = ctrl_q[`DMAIRQ_CTRL_CONT];

  ////////////////////////////////////////////////////////////////////////////
  // Return opcode decoder: ED then 4D on consecutive fetch cycles
  dmairq_ret_t ret_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ret_q <= DMAIRQ_RET_IDLE;
    end else if (fetch_start) begin
      case (ret_q)
        DMAIRQ_RET_IDLE, DMAIRQ_RET_HIT: ret_q <= (data_s == `DMAIRQ_RET_OP0) ? DMAIRQ_RET_GOT_ED : DMAIRQ_RET_IDLE;
        DMAIRQ_RET_GOT_ED: begin
          if (data_s == `DMAIRQ_RET_OP1) begin
            ret_q <= DMAIRQ_RET_HIT;
          end else if (data_s == `DMAIRQ_RET_OP0) begin
            ret_q <= DMAIRQ_RET_GOT_ED;
          end else begin
            ret_q <= DMAIRQ_RET_IDLE;
          end
        end
        default: ret_q <= DMAIRQ_RET_IDLE;
      endcase
    end else if (ret_q == DMAIRQ_RET_HIT) begin
      ret_q <= DMAIRQ_RET_IDLE;
    end
  end
  logic ret_hit;
  assign ret_hit = (ret_q == DMAIRQ_RET_HIT);

  // Return effect from opcode or from the equivalent control byte
  logic ret_any;
  assign ret_any = ret_hit || (wr_cmd && cmd_byte[`DMAIRQ_CMD_RETURN]);

  ////////////////////////////////////////////////////////////////////////////
  // Enable state; interrupt-on-ready defers re-enable to the return
  logic enable_armed_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      enabled_q <= 1'b0;
      enable_armed_q <= 1'b0;
    end else if (wr_cmd && cmd_byte[`DMAIRQ_CMD_DISABLE]) begin
      enabled_q <= 1'b0;
      enable_armed_q <= 1'b0;
    end else if (wr_cmd && cmd_byte[`DMAIRQ_CMD_ENABLE]) begin
      // Inside a service routine with the option on, enabling waits for the return
      if (ior_en && insvc_q) begin
        enable_armed_q <= 1'b1;
      end else begin
        enabled_q <= 1'b1;
      end
    end else if (ret_any && ior_en && enable_armed_q) begin
      enabled_q <= 1'b1;
      enable_armed_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt-on-ready latch: in continuous mode only the first ready counts
  logic ior_seen_q;
  logic ior_cause;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ior_seen_q <= 1'b0;
    end else if (!enabled_q || !ior_en) begin
      ior_seen_q <= 1'b0;
    end else if (ready_rise && cont_mode) begin
      ior_seen_q <= 1'b1;
    end
  end
  assign ior_cause = ior_en && enabled_q && ready_rise && !(cont_mode && ior_seen_q);

  // Ready served through the service routine: only an enable written inside it arms the request
  logic ior_go_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ior_go_q <= 1'b0;
    end else if (ret_any && ior_en && enable_armed_q) begin
      ior_go_q <= 1'b1;
    end else if (!ior_en || !enabled_q || i_task_done || (wr_cmd && cmd_byte[`DMAIRQ_CMD_DONE])) begin
      // Cleared when the task ends, so a finished task is not requested again
      ior_go_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending and in-service latches
  logic cause;
  logic ack_win;
  assign cause = irq_en && (ior_cause || i_block_cause);
  // Only the upstream-enabled device with a pending request takes the acknowledge
  assign ack_win = ack_start && pend_q && iei_s;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      insvc_q <= 1'b0;
    end else if (ack_win) begin
      insvc_q <= 1'b1;
    end else if (ret_any || (wr_cmd && cmd_byte[`DMAIRQ_CMD_RESET_IRQ])) begin
      insvc_q <= 1'b0;
    end
  end

  // Held cause re-pends once service ends; acknowledge wins over setting, setting wins over the reset command
  logic held_cause_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= 1'b0;
      held_cause_q <= 1'b0;
    end else begin
      if (ack_win) begin
        pend_q <= 1'b0;
        held_cause_q <= i_block_cause;
      end else if ((cause || (held_cause_q && i_block_cause)) && !insvc_q) begin
        pend_q <= 1'b1;
        held_cause_q <= 1'b0;
      end else if (wr_cmd && cmd_byte[`DMAIRQ_CMD_RESET_IRQ]) begin
        pend_q <= 1'b0;
        held_cause_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus request: held until the task completes once the bus is taken
  logic req_cond;
  assign req_cond = enabled_q && !insvc_q && (ior_en ? ior_go_q : ready_s);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bus_req_q <= 1'b0;
    end else if (insvc_q || !enabled_q || i_task_done || (wr_cmd && cmd_byte[`DMAIRQ_CMD_DONE])) begin
      bus_req_q <= 1'b0;
    end else if (req_cond) begin
      bus_req_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins, all registered
  logic [7:0] vector;
  // Status affects vector replaces low bits with pending cause and ready
  assign vector = ctrl_q[`DMAIRQ_CTRL_SAV] ? {vect_q[7:2], i_block_cause, ready_s} : vect_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_int_n <= 1'b1;
      o_chain_enable_out <= 1'b0;
      o_bus_request_n <= 1'b1;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_int_n <= !(pend_q && !insvc_q);
      o_chain_enable_out <= iei_s && !insvc_q && !pend_q;
      o_bus_request_n <= !(bus_req_q && !insvc_q);
      if (ack_win) begin
        o_data <= vector;
        o_data_oe <= 1'b1;
      end else if (!ack_s) begin
        o_data_oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_ack_taken;
    ack_win;
  endsequence
  sequence s_vector_out;
    ##1 o_data_oe;
  endsequence

  property p_vector_on_ack;
    @(posedge i_clk_sys) disable iff (i_rst) s_ack_taken |-> s_vector_out;
  endproperty
  a_vector_on_ack: assert property (p_vector_on_ack) else $error("Vector not driven after acknowledge");

  property p_int_follows_pend;
    @(posedge i_clk_sys) disable iff (i_rst) (pend_q && !insvc_q) |=> !o_int_n;
  endproperty
  a_int_follows_pend: assert property (p_int_follows_pend) else $error("Interrupt request not asserted");

  property p_no_int_in_service;
    @(posedge i_clk_sys) disable iff (i_rst) insvc_q |=> o_int_n;
  endproperty
  a_no_int_in_service: assert property (p_no_int_in_service) else $error("Interrupt while in service");

  property p_chain_low_in_service;
    @(posedge i_clk_sys) disable iff (i_rst) (insvc_q || !iei_s) |=> !o_chain_enable_out;
  endproperty
  a_chain_low_in_service: assert property (p_chain_low_in_service) else $error("Chain enable high");

  property p_no_bus_request_n_in_service;
    @(posedge i_clk_sys) disable iff (i_rst) $past(insvc_q) && insvc_q |-> o_bus_request_n;
  endproperty
  a_no_bus_request_n_in_service: assert property (p_no_bus_request_n_in_service) else $error("Bus request in service");

  property p_pend_clears_on_ack;
    @(posedge i_clk_sys) disable iff (i_rst) ack_win |=> insvc_q && !pend_q;
  endproperty
  a_pend_clears_on_ack: assert property (p_pend_clears_on_ack) else $error("Pending not cleared at service");

  property p_ret_clears_service;
    @(posedge i_clk_sys) disable iff (i_rst) (ret_hit && !ack_win) |=> !insvc_q;
  endproperty
  a_ret_clears_service: assert property (p_ret_clears_service) else $error("Return did not end service");

  property p_ready_to_bus_request_n;
    @(posedge i_clk_sys) disable iff (i_rst)
      (ready_rise && enabled_q && !ior_en && !insvc_q && !ack_win && !i_task_done && !wr_cmd)
        |-> ##[1:2] !o_bus_request_n;
  endproperty
  a_ready_to_bus_request_n: assert property (p_ready_to_bus_request_n) else $error("Bus request late after ready");

  property p_ior_no_bus_request_n;
    @(posedge i_clk_sys) disable iff (i_rst) (ior_en && !ior_go_q && !bus_req_q) |=> !bus_req_q;
  endproperty
  a_ior_no_bus_request_n: assert property (p_ior_no_bus_request_n) else $error("Bus requested on ready with option");
endmodule

/* File: dmairq_host_model.sv */
// Host CPU model: acknowledge cycles, opcode fetches and the shared data bus
`timescale 1ns/100ps
`include "dmairq_defs.svh"
module dmairq_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Device side of the bus
  input wire logic [7:0] i_dev_data,
  input wire logic i_dev_oe,
  // Host pins
  output logic o_opcode_fetch_n,
  output logic o_io_request_n,
  output logic [7:0] o_data
);
  logic drv_q = 1'b0;
  logic [7:0] val_q = 8'h00;
  logic [7:0] idle_q = 8'h5a;
  // A released bus flips every cycle, so a stale byte never passes as a vector
  assign o_data = i_dev_oe ? i_dev_data : (drv_q ? val_q : idle_q);
  always @(posedge i_clk_sys) idle_q <= ~o_data;
  initial begin
    o_opcode_fetch_n = 1'b1;
    o_io_request_n = 1'b1;
  end
  // Acknowledge: both pins low together, held until two cycles after the vector appears, or for 14 cycles if none does
  task automatic ack();
    int n;
    @(posedge i_clk_sys);
    o_opcode_fetch_n <= 1'b0;
    o_io_request_n <= 1'b0;
    for (n = 0; n < 12 && i_dev_oe !== 1'b1; n++) @(posedge i_clk_sys);
    repeat (2) @(posedge i_clk_sys);
    o_opcode_fetch_n <= 1'b1;
    o_io_request_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
  endtask
  // One opcode fetch, four clocks low
  task automatic fetch(input logic [7:0] op);
    @(posedge i_clk_sys);
    o_opcode_fetch_n <= 1'b0;
    drv_q <= 1'b1;
    val_q <= op;
    repeat (4) @(posedge i_clk_sys);
    o_opcode_fetch_n <= 1'b1;
    drv_q <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  // Return opcode as two consecutive fetches
  task automatic irq_return_opcode();
    fetch(`DMAIRQ_RET_OP0);
    fetch(`DMAIRQ_RET_OP1);
  endtask
endmodule

/* File: tb_dmairq_top.sv */
// Self-checking bench of the DMA interrupt logic
`timescale 1ns/100ps
`include "dmairq_defs.svh"
module tb_dmairq_top;
  import dmairq_pkg::*;
  logic i_clk_sys, i_rst, i_avs_read, i_avs_write, i_chain_enable_in, i_ready, i_block_cause, i_task_done;
  logic [3:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic o_avs_waitrequest, o_data_oe, o_int_n, o_chain_enable_out, o_bus_request_n;
  logic i_opcode_fetch_n, i_io_request_n;
  logic [7:0] i_data, o_data, vec;
  logic [31:0] lfsr_q = 32'h0756;
  logic [31:0] rdq[$];
  logic [7:0] vecq[$];
  logic oe_prev = 1'b0;
  int miscompares = 0, comparisons = 0, oe_rises = 0, seen, n;
  string nm[4] = '{"int_n", "bus_request_n", "chain_enable_out", "data_oe"};
  //////////////////////////////////////////////////////////////////////////////
  dmairq_top dmairq_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_opcode_fetch_n(i_opcode_fetch_n),
    .i_io_request_n(i_io_request_n), .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe), .o_int_n(o_int_n),
    .i_chain_enable_in(i_chain_enable_in), .o_chain_enable_out(o_chain_enable_out), .i_ready(i_ready),
    .i_block_cause(i_block_cause), .i_task_done(i_task_done), .o_bus_request_n(o_bus_request_n));
  dmairq_host_model dmairq_host_model_inst (.i_clk_sys(i_clk_sys), .i_dev_data(o_data), .i_dev_oe(o_data_oe),
    .o_opcode_fetch_n(i_opcode_fetch_n), .o_io_request_n(i_io_request_n), .o_data(i_data));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; a hang counts as a mismatch
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #300000;
    miscompares++;
    summarize();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: return o_int_n;
      1: return o_bus_request_n;
      2: return o_chain_enable_out;
      default: return o_data_oe;
    endcase
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait for an output level, then compare
  task automatic await(input int s, input logic v, input int lim);
    for (n = 0; n < lim && pick(s) !== v; n++) @(posedge i_clk_sys);
    chk(nm[s], {31'h0, v}, {31'h0, pick(s)});
  endtask
  // Avalon cycle held until waitrequest is seen low at a rising edge
  task automatic avs(input logic r, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_avs_read <= r;
    i_avs_write <= ~r;
    i_avs_address <= a;
    i_avs_writedata <= d;
    // No assumed latency: only the watchdog ends a stuck wait
    do begin
      @(posedge i_clk_sys);
    end while (o_avs_waitrequest !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    avs(1'b1, a, lfsr_q);
  endtask
  task automatic cmd(input int b);
    avs(1'b0, `DMAIRQ_OFF_CMD, 32'h1 << b);
  endtask
  // Watcher: read data and vectors against the oldest note
  always @(posedge i_clk_sys) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0 && rdq.size() > 0)
      chk("readdata", rdq.pop_front(), o_avs_readdata);
    if (o_data_oe === 1'b1 && !oe_prev) begin
      oe_rises++;
      if (vecq.size() > 0) chk("vector", {24'h0, vecq.pop_front()}, {24'h0, o_data});
    end
    oe_prev <= o_data_oe;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    i_chain_enable_in = 1'b1;
    i_ready = 1'b0;
    i_block_cause = 1'b0;
    i_task_done = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    chk("reset int_n", 1, o_int_n);
    chk("reset bus_request_n", 1, o_bus_request_n);
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    await(2, 1'b1, 8);
    rd(`DMAIRQ_OFF_CTRL, {28'h0, `DMAIRQ_CTRL_RST});
    rd(`DMAIRQ_OFF_VECT, {24'h0, `DMAIRQ_VECT_RST});
    rd(`DMAIRQ_OFF_STAT, 32'h0);
    avs(1'b0, 4'h2, 32'hff);
    rd(4'h2, 32'h0);
    $display("test reset done");
    // Plain ready: bus request, held until the task ends
    cmd(`DMAIRQ_CMD_ENABLE);
    i_ready <= 1'b1;
    await(1, 1'b0, `DMAIRQ_BUS_REQUEST_N_MAX_CYC + 3);
    i_ready <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    chk("held bus_request_n", 0, o_bus_request_n);
    i_task_done <= 1'b1;
    @(posedge i_clk_sys);
    i_task_done <= 1'b0;
    await(1, 1'b1, 4);
    cmd(`DMAIRQ_CMD_DISABLE);
    $display("test bus request done");
    // Interrupt on ready, service, return opcode re-enables requesting
    lfsr_q = lfsr(lfsr_q);
    vec = lfsr_q[7:0];
    avs(1'b0, `DMAIRQ_OFF_CTRL, 32'h3);
    avs(1'b0, `DMAIRQ_OFF_VECT, {24'h0, vec});
    cmd(`DMAIRQ_CMD_ENABLE);
    i_ready <= 1'b1;
    await(0, 1'b0, 8);
    chk("no bus_request_n", 1, o_bus_request_n);
    chk("pending chain_enable_out", 0, o_chain_enable_out);
    vecq.push_back(vec);
    dmairq_host_model_inst.ack();
    await(0, 1'b1, 2);
    cmd(`DMAIRQ_CMD_ENABLE);
    rd(`DMAIRQ_OFF_STAT, 32'h1a);
    chk("service chain_enable_out", 0, o_chain_enable_out);
    chk("service bus_request_n", 1, o_bus_request_n);
    dmairq_host_model_inst.irq_return_opcode();
    await(1, 1'b0, 10);
    i_ready <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    cmd(`DMAIRQ_CMD_DONE);
    cmd(`DMAIRQ_CMD_DISABLE);
    cmd(`DMAIRQ_CMD_RESET_IRQ);
    $display("test interrupt on ready done");
    // Lasting cause, status in vector, chain blocking, return opcode
    lfsr_q = lfsr(lfsr_q);
    vec = lfsr_q[7:0];
    avs(1'b0, `DMAIRQ_OFF_CTRL, 32'h9);
    avs(1'b0, `DMAIRQ_OFF_VECT, {24'h0, vec});
    i_block_cause <= 1'b1;
    await(0, 1'b0, 8);
    vecq.push_back({vec[7:2], 2'b10});
    dmairq_host_model_inst.ack();
    chk("acked int_n", 1, o_int_n);
    cmd(`DMAIRQ_CMD_RETURN);
    await(0, 1'b0, 8);
    i_chain_enable_in <= 1'b0;
    seen = oe_rises;
    dmairq_host_model_inst.ack();
    chk("vector while blocked", seen, oe_rises);
    chk("blocked int_n", 0, o_int_n);
    i_chain_enable_in <= 1'b1;
    vecq.push_back({vec[7:2], 2'b10});
    dmairq_host_model_inst.ack();
    i_block_cause <= 1'b0;
    dmairq_host_model_inst.irq_return_opcode();
    await(2, 1'b1, 8);
    chk("idle int_n", 1, o_int_n);
    i_chain_enable_in <= 1'b0;
    await(2, 1'b0, 6);
    $display("test lasting cause done");
    summarize();
  end
endmodule
